// >>> rtl/tdb_burst.sv
/*
 * Timer DMA burst-access front end: AXI4-Lite slave holding the burst
 * control register and the burst window, which redirects each window access
 * to the timer register file at control register one plus 4*(base+index).
 * Assumes the timer register file answers a forwarded access with TRG_ACK
 * (read data valid in that cycle) and that the DMA side issues
 * burst_length+1 window accesses per burst in word mode, twice that in byte mode.
 */
// Implementation choice: register access over AXI4-Lite.
`default_nettype none
`include "tdb_consts.svh"
module tdb_burst
    import tdb_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic BYTE_MODE,
    output logic [ADDR_W-1:0] TRG_ADDR,
    output logic TRG_REQ,
    output logic TRG_WRITE,
    output logic [15:0] TRG_WDATA,
    input wire logic [15:0] TRG_RDATA,
    input wire logic TRG_ACK
);
    logic [15:0] ctrl_q, ctrl_d;
    logic [4:0] idx_q, idx_d;
    logic [15:0] win_q, win_d;
    logic byte_hi_q, byte_hi_d;
    tdb_state_t wst_q, wst_d, rst_q, rst_d;
    logic [ADDR_W-1:0] awaddr_q, araddr_q;
    logic [15:0] wdata_q;
    logic [3:0] wstrb_q;
    logic aw_have_q, w_have_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;

    // Field split of the control register
    wire logic [4:0] base_f = ctrl_q[`TDB_BASE_MSB:`TDB_BASE_LSB];
    wire logic [4:0] len_f = ctrl_q[`TDB_LEN_MSB:`TDB_LEN_LSB];
    wire logic [5:0] sum_f = {1'b0, base_f} + {1'b0, idx_q};
    wire logic last_f = (idx_q == len_f);

    // Target address: ctrl1 plus four bytes per register step
    wire logic [ADDR_W-1:0] tgt_addr = ADDR_W'(`TDB_OFF_CTRL1) + ADDR_W'({sum_f, 2'b00});

    // Write decode once both halves are held
    // A write waits while a read owns the target port, so only one access moves the index
    wire logic wr_go = (wst_q == TDB_IDLE) && aw_have_q && w_have_q && (rst_q != TDB_FWD);
    wire logic wr_ctrl = wr_go && (awaddr_q == ADDR_W'(`TDB_OFF_BURST_CTRL));
    wire logic wr_win = wr_go && (awaddr_q == ADDR_W'(`TDB_OFF_BURST_WIN));
    wire logic wr_ok = wr_ctrl || wr_win;
    // Read decode when an address arrives and no write owns the target port
    // A window write decoded in the same cycle claims the port first
    wire logic rd_go = (rst_q == TDB_IDLE) && S_AXI_ARVALID && (wst_q != TDB_FWD) && !wr_win;
    wire logic rd_win = rd_go && (S_AXI_ARADDR == ADDR_W'(`TDB_OFF_BURST_WIN));
    wire logic fwd_wr = (wst_q == TDB_FWD);
    wire logic fwd_rd = (rst_q == TDB_FWD);
    // One access step of the burst finished at the target
    wire logic step_done = (fwd_wr || fwd_rd) && TRG_ACK;
    // In byte mode a step covers a register only on the second byte
    wire logic reg_done = step_done && (!BYTE_MODE || byte_hi_q);

    // Handshake outputs
    assign S_AXI_AWREADY = !aw_have_q && (wst_q == TDB_IDLE);
    assign S_AXI_WREADY = !w_have_q && (wst_q == TDB_IDLE);
    assign S_AXI_ARREADY = rd_go;
    assign S_AXI_BVALID = (wst_q == TDB_RESP);
    assign S_AXI_RVALID = (rst_q == TDB_RESP);
    assign S_AXI_BRESP = bresp_q;
    assign S_AXI_RRESP = rresp_q;
    assign S_AXI_RDATA = rdata_q;

    // Forwarded access to the timer register file
    assign TRG_REQ = fwd_wr || fwd_rd;
    assign TRG_WRITE = fwd_wr;
    assign TRG_ADDR = tgt_addr;
    // First byte lands in the upper half of the first register
    assign TRG_WDATA = !BYTE_MODE ? wdata_q :
        (byte_hi_q ? {win_q[15:8], wdata_q[7:0]} : {wdata_q[7:0], 8'h00});

    // Write channel phase
    always_comb begin
        wst_d = wst_q;
        case (wst_q)
            TDB_IDLE: if (wr_win) wst_d = TDB_FWD; else if (wr_go) wst_d = TDB_RESP;
            TDB_FWD: if (TRG_ACK) wst_d = TDB_RESP;
            TDB_RESP: if (S_AXI_BREADY) wst_d = TDB_IDLE;
            default: wst_d = TDB_IDLE;
        endcase
    end

    // Read channel phase
    always_comb begin
        rst_d = rst_q;
        case (rst_q)
            TDB_IDLE: if (rd_win) rst_d = TDB_FWD; else if (rd_go) rst_d = TDB_RESP;
            TDB_FWD: if (TRG_ACK) rst_d = TDB_RESP;
            TDB_RESP: if (S_AXI_RREADY) rst_d = TDB_IDLE;
            default: rst_d = TDB_IDLE;
        endcase
    end

    // Index steps per register and wraps after the last one
    always_comb begin
        idx_d = idx_q;
        byte_hi_d = byte_hi_q;
        if (wr_ctrl) begin
            idx_d = `TDB_IDX_RESET;
            byte_hi_d = 1'b0;
        end else if (step_done) begin
            byte_hi_d = BYTE_MODE && !byte_hi_q;
            if (reg_done) begin
                idx_d = last_f ? `TDB_IDX_RESET : idx_q + 5'h01;
            end
        end
    end

    // Byte lanes of the control register; reserved bits stay zero
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_ctrl) begin
            if (wstrb_q[0]) ctrl_d[7:0] = wdata_q[7:0];
            if (wstrb_q[1]) ctrl_d[15:8] = wdata_q[15:8];
            ctrl_d = ctrl_d & `TDB_CTRL_MASK;
        end
    end

    // Window holds the last value moved through it
    always_comb begin
        win_d = win_q;
        if (fwd_wr && TRG_ACK) win_d = TRG_WDATA;
        else if (fwd_rd && TRG_ACK) win_d = TRG_RDATA;
    end

    // Capture of the bus requests
    always_ff @(posedge CLK) begin
        if (RST) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= 16'h0000;
            wstrb_q <= 4'h0;
            araddr_q <= '0;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_have_q <= 1'b1;
                awaddr_q <= S_AXI_AWADDR;
            end else if (wr_go) aw_have_q <= 1'b0;
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_have_q <= 1'b1;
                wdata_q <= S_AXI_WDATA[15:0];
                wstrb_q <= S_AXI_WSTRB;
            end else if (wr_go) w_have_q <= 1'b0;
            if (rd_go) araddr_q <= S_AXI_ARADDR;
        end
    end

    // Answers: unmapped addresses get SLVERR, window read returns target data
    always_ff @(posedge CLK) begin
        if (RST) begin
            bresp_q <= `TDB_RESP_OKAY;
            rresp_q <= `TDB_RESP_OKAY;
            rdata_q <= 32'h0000_0000;
        end else begin
            if (wr_go) bresp_q <= wr_ok ? `TDB_RESP_OKAY : `TDB_RESP_SLVERR;
            if (rd_go) begin
                rresp_q <= `TDB_RESP_OKAY;
                rdata_q <= 32'h0000_0000;
                if (S_AXI_ARADDR == ADDR_W'(`TDB_OFF_BURST_CTRL)) rdata_q <= {16'h0000, ctrl_q};
                else if (S_AXI_ARADDR == ADDR_W'(`TDB_OFF_BURST_STAT))
                    rdata_q <= {26'h0, byte_hi_q, idx_q};
                else if (!rd_win) rresp_q <= `TDB_RESP_SLVERR;
            end else if (fwd_rd && TRG_ACK) rdata_q <= {16'h0000, TRG_RDATA};
        end
    end

    // State registers
    always_ff @(posedge CLK) begin
        if (RST) begin
            wst_q <= TDB_IDLE;
            rst_q <= TDB_IDLE;
            ctrl_q <= `TDB_CTRL_RESET;
            idx_q <= `TDB_IDX_RESET;
            win_q <= `TDB_WIN_RESET;
            byte_hi_q <= 1'b0;
        end else begin
            wst_q <= wst_d;
            rst_q <= rst_d;
            ctrl_q <= ctrl_d;
            idx_q <= idx_d;
            win_q <= win_d;
            byte_hi_q <= byte_hi_d;
        end
    end

    // Last register of the burst has just been completed
    sequence s_last_reg;
        reg_done && last_f;
    endsequence

    a_addr_formula: assert property (@(posedge CLK) disable iff (RST)
        TRG_REQ |-> TRG_ADDR == ADDR_W'(`TDB_OFF_CTRL1) + ADDR_W'(4 * (base_f + idx_q)))
        else $error("Target address off formula");
    a_index_wrap: assert property (@(posedge CLK) disable iff (RST)
        s_last_reg |=> idx_q == 5'h00)
        else $error("Index did not wrap after last register");
    a_index_step: assert property (@(posedge CLK) disable iff (RST)
        (reg_done && !last_f && !wr_ctrl) |=> idx_q == $past(idx_q) + 5'h01)
        else $error("Index did not advance");
    a_index_limit: assert property (@(posedge CLK) disable iff (RST)
        idx_q <= len_f || $changed(ctrl_q))
        else $error("Index beyond burst length");
    a_index_hold: assert property (@(posedge CLK) disable iff (RST)
        (!step_done && !wr_ctrl) |=> $stable(idx_q))
        else $error("Index moved without an access");
    a_window_fwd: assert property (@(posedge CLK) disable iff (RST)
        (wr_win || rd_win) |=> TRG_REQ ##0 (TRG_WRITE == $past(wr_win)))
        else $error("Window access not forwarded");
    a_byte_msb: assert property (@(posedge CLK) disable iff (RST)
        (fwd_wr && BYTE_MODE && !byte_hi_q) |-> TRG_WDATA[15:8] == wdata_q[7:0])
        else $error("First byte not in upper half");
    a_byte_pair: assert property (@(posedge CLK) disable iff (RST)
        (step_done && BYTE_MODE && !byte_hi_q) |=> $stable(idx_q) && byte_hi_q)
        else $error("Byte mode stepped register early");
    a_base_mask: assert property (@(posedge CLK) disable iff (RST)
        (ctrl_q & ~`TDB_CTRL_MASK) == 16'h0000)
        else $error("Reserved control bits set");

    // A finished forwarded write, and a finished forwarded read
    sequence s_fwd_wr_done;
        fwd_wr && TRG_ACK;
    endsequence
    sequence s_fwd_rd_done;
        fwd_rd && TRG_ACK;
    endsequence

    // Only one access may own the target port at a time
    a_port_single: assert property (@(posedge CLK) disable iff (RST)
        !(fwd_wr && fwd_rd))
        else $error("Read and write forwarded together");
    // A forwarded request stays put until the register file answers
    a_req_steady: assert property (@(posedge CLK) disable iff (RST)
        (TRG_REQ && !TRG_ACK) |=> TRG_REQ && $stable(TRG_ADDR) && $stable(TRG_WRITE))
        else $error("Forwarded request changed before acknowledge");
    a_wr_answer: assert property (@(posedge CLK) disable iff (RST)
        s_fwd_wr_done |=> S_AXI_BVALID && (S_AXI_BRESP == `TDB_RESP_OKAY))
        else $error("Window write not answered");
    a_rd_answer: assert property (@(posedge CLK) disable iff (RST)
        s_fwd_rd_done |=> S_AXI_RVALID && (S_AXI_RDATA == {16'h0000, $past(TRG_RDATA)}))
        else $error("Window read data not returned");
    a_unmapped_err: assert property (@(posedge CLK) disable iff (RST)
        (wr_go && !wr_ok) |=> S_AXI_BVALID && (S_AXI_BRESP == `TDB_RESP_SLVERR))
        else $error("Unmapped write not refused");
    // Answers stand until the master takes them
    a_bvalid_hold: assert property (@(posedge CLK) disable iff (RST)
        (S_AXI_BVALID && !S_AXI_BREADY) |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("Write answer dropped early");
    a_rvalid_hold: assert property (@(posedge CLK) disable iff (RST)
        (S_AXI_RVALID && !S_AXI_RREADY) |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("Read answer dropped early");
    // Writing the control register restarts the burst
    a_ctrl_restart: assert property (@(posedge CLK) disable iff (RST)
        wr_ctrl |=> (idx_q == 5'h00) && !byte_hi_q)
        else $error("Control write did not restart burst");
    // Word items pass through untouched
    a_word_pass: assert property (@(posedge CLK) disable iff (RST)
        (fwd_wr && !BYTE_MODE) |-> TRG_WDATA == wdata_q)
        else $error("Word item altered on the way");
    // Reads outside the three mapped words are refused
    a_rd_refuse: assert property (@(posedge CLK) disable iff (RST)
        (rd_go && !rd_win && (S_AXI_ARADDR != ADDR_W'(`TDB_OFF_BURST_CTRL))
            && (S_AXI_ARADDR != ADDR_W'(`TDB_OFF_BURST_STAT)))
            |=> S_AXI_RVALID && (S_AXI_RRESP == `TDB_RESP_SLVERR))
        else $error("Unmapped read not refused");
    // Control reads return the register as it stood when the address came
    a_ctrl_read: assert property (@(posedge CLK) disable iff (RST)
        (rd_go && (S_AXI_ARADDR == ADDR_W'(`TDB_OFF_BURST_CTRL)))
            |=> S_AXI_RDATA == {16'h0000, $past(ctrl_q)})
        else $error("Control read data wrong");
endmodule : tdb_burst
`default_nettype wire

// >>> rtl/tdb_consts.svh
/*
 * Constants of the timer DMA burst front end: register byte offsets, field
 * positions, reset values and the target register base.
 * Assumes inclusion by bare name from the design file and the bench.
 */
`ifndef TDB_CONSTS_SVH
`define TDB_CONSTS_SVH

`define TDB_OFF_CTRL1 8'h00
`define TDB_OFF_BURST_CTRL 8'h48
`define TDB_OFF_BURST_WIN 8'h4C
`define TDB_OFF_BURST_STAT 8'h50
`define TDB_BASE_LSB 0
`define TDB_BASE_MSB 4
`define TDB_LEN_LSB 8
`define TDB_LEN_MSB 12
`define TDB_CTRL_MASK 16'h1F1F
`define TDB_CTRL_RESET 16'h0000
`define TDB_WIN_RESET 16'h0000
`define TDB_IDX_RESET 5'h00
`define TDB_RESP_OKAY 2'h0
`define TDB_RESP_SLVERR 2'h2

`endif

// >>> rtl/tdb_pkg.sv
/*
 * Types of the timer DMA burst front end.
 * Assumes tdb_consts.svh sits on the include path.
 */
`default_nettype none
package tdb_pkg;
    // Bus-slave phase; Gray codes along idle, busy, answer
    typedef enum logic [1:0] {
        TDB_IDLE = 2'b00,
        TDB_FWD = 2'b01,
        TDB_RESP = 2'b11
    } tdb_state_t;
    // Size of one window data item
    typedef enum logic {
        TDB_SIZE16 = 1'b0,
        TDB_SIZE8 = 1'b1
    } tdb_size_t;
endpackage : tdb_pkg
`default_nettype wire

// >>> test/tb_top.sv
/* Self-checking bench: AXI4-Lite master tasks and burst sequences.
   Assumes the timer register file model answers the target port. */
`default_nettype none
`include "tdb_consts.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic byte_mode = 1'b0;
    logic [3:0] dly = 4'h0;
    logic [3:0] wstrb = 4'hF;
    wire logic awready, wready, bvalid, arready, rvalid, trg_req, trg_write, trg_ack;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [7:0] trg_addr;
    wire logic [15:0] trg_wdata, trg_rdata;
    int n_errors = 0, cmp_count = 0;
    logic [31:0] rd;
    logic [1:0] rs;
    tdb_burst tdb_burst_inst (.CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .BYTE_MODE(byte_mode), .TRG_ADDR(trg_addr),
        .TRG_REQ(trg_req), .TRG_WRITE(trg_write), .TRG_WDATA(trg_wdata),
        .TRG_RDATA(trg_rdata), .TRG_ACK(trg_ack));
    tdb_regfile_model tdb_regfile_model_inst (.CLK(clk), .RST(rst), .TRG_ADDR(trg_addr),
        .TRG_REQ(trg_req), .TRG_WRITE(trg_write), .TRG_WDATA(trg_wdata), .DLY(dly),
        .TRG_RDATA(trg_rdata), .TRG_ACK(trg_ack));
    // Clock of 25 ns
    initial begin
        forever #12.5 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Ready is sampled at the falling edge, where it is settled, and acted on at the next rise
    task automatic axi_write(input logic [7:0] a, input logic [15:0] d, output logic [1:0] r);
        logic pa, pw, ga, gw;
        pa = 1'b1;
        pw = 1'b1;
        @(posedge clk);
        awaddr <= a;
        wdata <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (pa || pw) begin
            @(negedge clk);
            ga = pa && (awready === 1'b1);
            gw = pw && (wready === 1'b1);
            @(posedge clk);
            if (ga) awvalid <= 1'b0;
            if (gw) wvalid <= 1'b0;
            pa = pa && !ga;
            pw = pw && !gw;
        end
        do @(negedge clk); while (bvalid !== 1'b1);
        r = bresp;
        @(posedge clk);
        bready <= 1'b0;
    endtask : axi_write
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge clk); while (arready !== 1'b1);
        @(posedge clk);
        arvalid <= 1'b0;
        do @(negedge clk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        @(posedge clk);
        rready <= 1'b0;
    endtask : axi_read
    task automatic final_report;
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report
    // Watchdog; the whole sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        final_report();
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        axi_read(`TDB_OFF_BURST_CTRL, rd, rs);
        check(rd, 32'h0000_0000);
        axi_write(`TDB_OFF_BURST_CTRL, 16'hFFFF, rs);
        check(32'(rs), 32'(`TDB_RESP_OKAY));
        axi_read(`TDB_OFF_BURST_CTRL, rd, rs);
        check(rd, 32'h0000_1F1F);
        // Only the low lane is strobed: the length field must survive
        wstrb <= 4'h1;
        axi_write(`TDB_OFF_BURST_CTRL, 16'h0000, rs);
        wstrb <= 4'hF;
        axi_read(`TDB_OFF_BURST_CTRL, rd, rs);
        check(rd, 32'h0000_1F00);
        axi_read(8'h60, rd, rs);
        check(32'(rs), 32'(`TDB_RESP_SLVERR));
        axi_write(`TDB_OFF_BURST_STAT, 16'h0001, rs);
        check(32'(rs), 32'(`TDB_RESP_SLVERR));
        // Burst of 18 registers from base 0; the extra access must wrap to index 0
        axi_write(`TDB_OFF_BURST_CTRL, 16'h1100, rs);
        for (int i = 0; i < 19; i++) axi_write(`TDB_OFF_BURST_WIN, 16'(16'hA000 + i), rs);
        for (int i = 0; i < 19; i++) begin
            check(32'(tdb_regfile_model_inst.mem_q[i]),
                  (i == 0) ? 32'hA012 : (i == 18) ? 32'h0 : 32'(32'hA000 + i));
        end
        // Three reads from base 2 against a slow register file
        dly <= 4'h3;
        axi_write(`TDB_OFF_BURST_CTRL, 16'h0202, rs);
        for (int i = 0; i < 3; i++) begin
            axi_read(`TDB_OFF_BURST_WIN, rd, rs);
            check(rd, 32'(32'hA002 + i));
            check(32'(rs), 32'(`TDB_RESP_OKAY));
        end
        // Byte items: the same two registers take four accesses, first byte high
        byte_mode <= 1'b1;
        axi_write(`TDB_OFF_BURST_CTRL, 16'h0114, rs);
        axi_write(`TDB_OFF_BURST_WIN, 16'h5656, rs);
        // Half a register done: byte phase set, index not yet moved
        axi_read(`TDB_OFF_BURST_STAT, rd, rs);
        check(rd, 32'h0000_0020);
        axi_write(`TDB_OFF_BURST_WIN, 16'h7878, rs);
        axi_write(`TDB_OFF_BURST_WIN, 16'h9A9A, rs);
        axi_write(`TDB_OFF_BURST_WIN, 16'hBCBC, rs);
        check(32'(tdb_regfile_model_inst.mem_q[20]), 32'h5678);
        check(32'(tdb_regfile_model_inst.mem_q[21]), 32'h9ABC);
        check(32'(tdb_regfile_model_inst.mem_q[22]), 32'h0000);
        final_report();
    end
endmodule : tb_top
`default_nettype wire

// >>> test/tdb_regfile_model.sv
/* Behavioural timer register file behind the burst front end.
   Assumes the front end's clock and synchronous reset. */
`default_nettype none
module tdb_regfile_model (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [7:0] TRG_ADDR,
    input wire logic TRG_REQ,
    input wire logic TRG_WRITE,
    input wire logic [15:0] TRG_WDATA,
    input wire logic [3:0] DLY,
    output logic [15:0] TRG_RDATA,
    output logic TRG_ACK
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] mem_q [32];
    logic [15:0] last_q;
    logic [3:0] cnt_q;
    logic ack_q;
    wire logic [4:0] slot = TRG_ADDR[6:2];
    // Data is valid only with the acknowledge; stale lines show the inverse
    assign TRG_RDATA = ack_q ? mem_q[slot] : ~last_q;
    assign TRG_ACK = ack_q;
    // One acknowledge pulse after DLY+1 wait cycles, so slow answers are exercised
    always_ff @(posedge CLK) begin
        if (RST) begin
            ack_q <= 1'b0;
            cnt_q <= 4'h0;
            last_q <= 16'h0000;
            for (int i = 0; i < 32; i++) mem_q[i] <= 16'h0000;
        end else begin
            ack_q <= TRG_REQ && !ack_q && (cnt_q == DLY);
            cnt_q <= (TRG_REQ && !ack_q) ? cnt_q + 4'h1 : 4'h0;
            if (ack_q) last_q <= TRG_RDATA;
            if (ack_q && TRG_WRITE) mem_q[slot] <= TRG_WDATA;
        end
    end
endmodule : tdb_regfile_model
`default_nettype wire
